// File: asr_pkg.sv
// Constants and types for the converter power and reference control
package asr_pkg;
  localparam int CODE_W = 10;
  localparam int CH_W = 4;
  localparam int SEL_W = 3;
  localparam int SEL_INT_BIT = 2;
  localparam int SEL_PIN_BIT = 1;
  localparam int SEL_KEEP_BIT = 0;
  // Power-on setup and configuration
  localparam logic [SEL_W-1:0] SEL_RST = 3'h0;
  localparam logic CLK_EXT_RST = 1'b0;
  localparam logic BIP_RST = 1'b0;
  localparam logic SGL_RST = 1'b1;
  localparam logic [1:0] SCAN_RST = 2'h3;
  localparam logic [CH_W-1:0] CS_RST = 4'h0;
  // Scan mode codes
  localparam logic [1:0] SCAN_UP = 2'h0;
  localparam logic [1:0] SCAN_REP = 2'h1;
  localparam logic [1:0] SCAN_MID = 2'h2;
  localparam logic [1:0] SCAN_ONE = 2'h3;
  localparam int REPEAT_N = 8;
  // Internal reference settling, informative to the master only
  localparam int REF_WAKE_MS = 10;
  localparam int CLK_MHZ = 200;
  localparam int REF_WAKE_CYC = REF_WAKE_MS * 1000 * CLK_MHZ;
  typedef enum logic [1:0] {ST_IDLE, ST_WAKE, ST_CONV, ST_HOLD} asr_state_e;
endpackage

// File: asr_power_ctrl.sv
// Automatic shutdown, reference select and result memory control
`timescale 1ns/1ps
`default_nettype none
module asr_power_ctrl #(
  parameter int NUM_CH       = 12,
  parameter int REF_WAKE_CYC = asr_pkg::REF_WAKE_CYC
) (
  // Clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        nrst,
  // Two-wire bus events, one-cycle pulses
  input  wire logic                        bus_start_p,
  input  wire logic                        bus_stop_p,
  input  wire logic                        bus_nack_p,
  input  wire logic                        addr_rd_p,
  input  wire logic                        res_rd_p,
  // Setup and configuration writes
  input  wire logic                        setup_wr_p,
  input  wire logic [asr_pkg::SEL_W-1:0]   setup_sel,
  input  wire logic                        setup_clk_ext,
  input  wire logic                        setup_bipolar,
  input  wire logic                        cfg_wr_p,
  input  wire logic [1:0]                  cfg_scan,
  input  wire logic [asr_pkg::CH_W-1:0]    cfg_chan,
  input  wire logic                        cfg_single,
  // Analog converter
  input  wire logic                        conv_done_p,
  input  wire logic [asr_pkg::CODE_W-1:0]  conv_raw,
  output logic                             conv_start_p,
  output logic [asr_pkg::CH_W-1:0]         conv_chan,
  output logic                             conv_diff,
  output logic                             conv_ref_gnd,
  // Power and reference
  output logic                             analog_pwr_on,
  output logic                             int_ref_on,
  output logic                             ref_settled,
  output logic                             ref_pin_oe_n,
  output logic                             pin_is_ref,
  // Results
  output logic                             scl_hold,
  output logic                             res_vld_p,
  output logic [asr_pkg::CODE_W-1:0]       res_data,
  output logic                             mem_ready
);
  localparam int MEM_D = (NUM_CH > asr_pkg::REPEAT_N) ? NUM_CH : asr_pkg::REPEAT_N;
  localparam logic [asr_pkg::CH_W-1:0] TOP_CH  = asr_pkg::CH_W'(NUM_CH - 1);
  localparam logic [asr_pkg::CH_W-1:0] CAP_REF = asr_pkg::CH_W'(NUM_CH - 2);
  localparam logic [asr_pkg::CH_W-1:0] MID_CH  = asr_pkg::CH_W'(NUM_CH / 2);
  localparam logic [2:0] REP_LAST = 3'(asr_pkg::REPEAT_N - 1);
  if (!(NUM_CH == 4 || NUM_CH == 12) || REF_WAKE_CYC < 1) begin : g_bad_param
    $error("asr_power_ctrl: NUM_CH must be 4 or 12, REF_WAKE_CYC at least 1");
  end
  logic                         rst_meta_r;
  logic                         rst_n_r;
  asr_pkg::asr_state_e          st_r;
  asr_pkg::asr_state_e          st_nxt;
  logic [asr_pkg::SEL_W-1:0]    sel_r;
  logic                         clk_ext_r;
  logic                         bip_r;
  logic [1:0]                   scan_r;
  logic [asr_pkg::CH_W-1:0]     cs_r;
  logic                         single_r;
  logic                         armed_r;
  logic                         multi_r;
  logic [asr_pkg::CH_W-1:0]     first_r;
  logic [asr_pkg::CH_W-1:0]     last_r;
  logic [2:0]                   rep_r;
  logic [2:0]                   rep_tgt_r;
  logic [asr_pkg::CH_W-1:0]     wr_ptr_r;
  logic [asr_pkg::CH_W-1:0]     rd_ptr_r;
  logic [31:0]                  wake_cnt_r;
  logic [asr_pkg::CODE_W-1:0]   mem_r [MEM_D];
  logic [asr_pkg::CH_W-1:0]     lim;
  logic [asr_pkg::CH_W-1:0]     cs_lim;
  logic [asr_pkg::CH_W-1:0]     first_ch;
  logic [asr_pkg::CH_W-1:0]     last_ch;
  logic [2:0]                   reps_last;
  logic                         multi;
  logic [asr_pkg::CH_W:0]       ch_step;
  logic [asr_pkg::CH_W-1:0]     ch_adv;
  logic                         last_item;
  logic                         end_ev;
  logic                         pwr_nxt;
  logic [asr_pkg::CODE_W-1:0]   coded;
  // Shared pin sits as the odd member of the top differential pair
  function automatic logic pin_pair(input logic [asr_pkg::CH_W-1:0] ch);
    return (ch | 4'h1) == TOP_CH;
  endfunction
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // Setup and configuration registers
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sel_r      <= asr_pkg::SEL_RST;
      pin_is_ref <= asr_pkg::SEL_RST[asr_pkg::SEL_PIN_BIT];
      clk_ext_r  <= asr_pkg::CLK_EXT_RST;
      bip_r      <= asr_pkg::BIP_RST;
      scan_r     <= asr_pkg::SCAN_RST;
      cs_r       <= asr_pkg::CS_RST;
      single_r   <= asr_pkg::SGL_RST;
    end else begin
      if (setup_wr_p) begin
        sel_r      <= setup_sel;
        pin_is_ref <= setup_sel[asr_pkg::SEL_PIN_BIT];
        clk_ext_r  <= setup_clk_ext;
        bip_r      <= setup_bipolar;
      end
      if (cfg_wr_p) begin
        scan_r   <= cfg_scan;
        cs_r     <= cfg_chan;
        single_r <= cfg_single;
      end
    end
  end

  // Internal reference: only a setup write moves it, never shutdown
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      int_ref_on <= 1'b0;
    end else if (setup_wr_p && setup_sel != sel_r) begin
      int_ref_on <= setup_sel[asr_pkg::SEL_INT_BIT] &
                    setup_sel[asr_pkg::SEL_KEEP_BIT];
    end
  end

  // Settling flag for the master; conversions never wait on it
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      wake_cnt_r  <= 32'h0000_0000;
      ref_settled <= 1'b0;
    end else if (!int_ref_on) begin
      wake_cnt_r  <= 32'h0000_0000;
      ref_settled <= 1'b0;
    end else if (!ref_settled) begin
      wake_cnt_r  <= wake_cnt_r + 32'h0000_0001;
      ref_settled <= (wake_cnt_r == 32'(REF_WAKE_CYC - 1));
    end
  end

  // Start seen, waiting for our address
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      armed_r <= 1'b0;
    end else if (bus_start_p) begin
      armed_r <= 1'b1;
    end else if (addr_rd_p || bus_stop_p) begin
      armed_r <= 1'b0;
    end
  end

  // Sequence bounds, limiter keeps scans off the shared pin
  always_comb begin
    lim       = pin_is_ref ? CAP_REF : TOP_CH;
    cs_lim    = (cs_r > lim) ? lim : cs_r;
    first_ch  = cs_r;
    last_ch   = cs_r;
    reps_last = 3'h0;
    multi     = 1'b0;
    case (scan_r)
      asr_pkg::SCAN_UP: begin
        first_ch = 4'h0;
        last_ch  = cs_lim;
        multi    = 1'b1;
      end
      asr_pkg::SCAN_REP: begin
        reps_last = clk_ext_r ? 3'h0 : REP_LAST;
      end
      asr_pkg::SCAN_MID: begin
        first_ch = MID_CH;
        last_ch  = (cs_lim < MID_CH) ? MID_CH : cs_lim;
        multi    = 1'b1;
      end
      default: ;
    endcase
  end

  always_comb begin
    ch_step   = {1'b0, conv_chan} + (single_r ? 5'h01 : 5'h02);
    ch_adv    = ch_step[asr_pkg::CH_W-1:0];
    last_item = (rep_r == rep_tgt_r) && (ch_step > {1'b0, last_r});
    end_ev    = bus_stop_p || bus_nack_p || bus_start_p;
    coded     = bip_r ? {~conv_raw[asr_pkg::CODE_W-1], conv_raw[asr_pkg::CODE_W-2:0]}
                      : conv_raw;
  end

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      asr_pkg::ST_IDLE: begin
        if (addr_rd_p && armed_r) begin
          st_nxt = asr_pkg::ST_WAKE;
        end
      end
      asr_pkg::ST_WAKE: begin
        st_nxt = asr_pkg::ST_CONV;
      end
      asr_pkg::ST_CONV: begin
        if (clk_ext_r && end_ev) begin
          st_nxt = asr_pkg::ST_IDLE;
        end else if (!clk_ext_r && conv_done_p && last_item) begin
          st_nxt = asr_pkg::ST_HOLD;
        end
      end
      asr_pkg::ST_HOLD: begin
        if (bus_stop_p || bus_start_p) begin
          st_nxt = asr_pkg::ST_IDLE;
        end
      end
      default: st_nxt = asr_pkg::ST_IDLE;
    endcase
    pwr_nxt = (st_nxt == asr_pkg::ST_WAKE) || (st_nxt == asr_pkg::ST_CONV);
  end

  // State, power and pin drive
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      st_r          <= asr_pkg::ST_IDLE;
      analog_pwr_on <= 1'b0;
      ref_pin_oe_n  <= 1'b1;
      scl_hold      <= 1'b0;
      mem_ready     <= 1'b0;
    end else begin
      st_r          <= st_nxt;
      analog_pwr_on <= pwr_nxt;
      ref_pin_oe_n  <= !(pwr_nxt && sel_r[asr_pkg::SEL_INT_BIT] &&
                         sel_r[asr_pkg::SEL_PIN_BIT]);
      scl_hold      <= pwr_nxt && !clk_ext_r;
      mem_ready     <= (st_nxt == asr_pkg::ST_HOLD);
    end
  end

  // Conversion sequencing
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      conv_start_p <= 1'b0;
      conv_chan    <= asr_pkg::CS_RST;
      conv_diff    <= 1'b0;
      conv_ref_gnd <= 1'b0;
      first_r      <= 4'h0;
      last_r       <= 4'h0;
      rep_r        <= 3'h0;
      rep_tgt_r    <= 3'h0;
      multi_r      <= 1'b0;
    end else begin
      conv_start_p <= 1'b0;
      if (st_r == asr_pkg::ST_IDLE && st_nxt == asr_pkg::ST_WAKE) begin
        conv_chan    <= first_ch;
        conv_diff    <= !single_r;
        conv_ref_gnd <= pin_is_ref && !single_r && pin_pair(first_ch);
        first_r      <= first_ch;
        last_r       <= last_ch;
        rep_r        <= 3'h0;
        rep_tgt_r    <= reps_last;
        multi_r      <= multi;
      end else if (st_r == asr_pkg::ST_WAKE) begin
        conv_start_p <= 1'b1;
      end else if (st_r == asr_pkg::ST_CONV && conv_done_p && st_nxt == asr_pkg::ST_CONV) begin
        conv_start_p <= 1'b1;
        if (last_item) begin
          conv_chan    <= first_r;
          conv_ref_gnd <= pin_is_ref && conv_diff && pin_pair(first_r);
          rep_r        <= 3'h0;
        end else if (rep_r != rep_tgt_r) begin
          rep_r <= rep_r + 3'h1;
        end else begin
          rep_r        <= 3'h0;
          conv_chan    <= ch_adv;
          conv_ref_gnd <= pin_is_ref && conv_diff && pin_pair(ch_adv);
        end
      end
    end
  end

  // Result memory, kept through shutdown
  always_ff @(posedge sys_clk) begin
    if (st_r == asr_pkg::ST_CONV && conv_done_p && !clk_ext_r) begin
      mem_r[wr_ptr_r] <= coded;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      wr_ptr_r  <= 4'h0;
      rd_ptr_r  <= 4'h0;
      res_vld_p <= 1'b0;
      res_data  <= 10'h000;
    end else begin
      res_vld_p <= 1'b0;
      if (st_r == asr_pkg::ST_WAKE) begin
        wr_ptr_r <= 4'h0;
        rd_ptr_r <= 4'h0;
      end else if (st_r == asr_pkg::ST_CONV && conv_done_p) begin
        if (clk_ext_r) begin
          res_data  <= coded;
          res_vld_p <= 1'b1;
        end else begin
          wr_ptr_r <= wr_ptr_r + 4'h1;
        end
      end else if (st_r == asr_pkg::ST_HOLD && res_rd_p) begin
        res_data  <= mem_r[rd_ptr_r];
        res_vld_p <= 1'b1;
        rd_ptr_r  <= (rd_ptr_r == wr_ptr_r - 4'h1) ? 4'h0 : rd_ptr_r + 4'h1;
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n_r);
  a_ext_keeps_conv: assert property ((st_r == asr_pkg::ST_CONV && clk_ext_r && !end_ev)
    |=> st_r == asr_pkg::ST_CONV) else $error("bus-clocked mode left conversion early");
  a_int_powers_down: assert property ((st_r == asr_pkg::ST_CONV && !clk_ext_r && conv_done_p
    && last_item) |=> (!analog_pwr_on && mem_ready)) else $error("no power-down after store");
  a_hold_keeps_mem: assert property ((st_r == asr_pkg::ST_HOLD && !bus_stop_p && !bus_start_p)
    |=> mem_ready) else $error("results lost before stop or restart");
  a_addr_wakes_up: assert property ((st_r == asr_pkg::ST_IDLE && armed_r && addr_rd_p)
    |=> analog_pwr_on ##1 (analog_pwr_on && conv_start_p)) else $error("no power-up on address");
  a_ref_only_setup: assert property (!setup_wr_p |=> $stable(int_ref_on))
    else $error("reference moved without setup write");
  a_ref_decode_ok: assert property ((setup_wr_p && setup_sel != sel_r) |=>
    int_ref_on == ($past(setup_sel[2]) & $past(setup_sel[0]))) else $error("bad reference decode");
  a_pin_hiz_off: assert property (!analog_pwr_on |-> ref_pin_oe_n)
    else $error("reference pin driven in shutdown");
  a_limit_scan: assert property ((conv_start_p && multi_r && single_r && pin_is_ref)
    |-> conv_chan <= CAP_REF) else $error("scan reached shared pin");
  a_code_format: assert property ((st_r == asr_pkg::ST_CONV && clk_ext_r && conv_done_p) |=>
    (res_vld_p && res_data == (bip_r ? {~$past(conv_raw[9]), $past(conv_raw[8:0])}
    : $past(conv_raw)))) else $error("bad output coding");
  c_int_cycle: cover property (st_r == asr_pkg::ST_CONV ##[1:200] st_r == asr_pkg::ST_HOLD);
  c_ext_stop: cover property (st_r == asr_pkg::ST_CONV && clk_ext_r && bus_nack_p);
  c_hold_read: cover property (st_r == asr_pkg::ST_HOLD && res_rd_p);
endmodule // asr_power_ctrl
`default_nettype wire

// File: asr_conv_model.sv
// Behavioural analog converter facing the control block
`timescale 1ns/1ps
`default_nettype none
module asr_conv_model (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  // Conversion handshake
  input  wire logic       conv_start_p,
  output var  logic       conv_done_p,
  output var  logic [9:0] conv_raw
);
  logic [31:0] rng_r;
  int          wait_r;

  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  // Raw word churns every cycle, so a late sample never sees the result
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rng_r       <= 32'hccc3_e329;
      wait_r      <= 0;
      conv_done_p <= 1'b0;
    end else begin
      rng_r       <= xs(rng_r);
      conv_done_p <= (wait_r == 1);
      if (conv_start_p)
        wait_r <= 2 + int'(rng_r[2:0]);
      else if (wait_r > 0)
        wait_r <= wait_r - 1;
    end
  end
  assign conv_raw = rng_r[9:0];
endmodule // asr_conv_model
`default_nettype wire

// File: tb_top.sv
// Self-checking testbench for the power and reference control
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int WAKE = 20;
  logic       sys_clk, nrst, bus_start_p, bus_stop_p, bus_nack_p;
  logic       addr_rd_p, res_rd_p, setup_wr_p, setup_clk_ext, setup_bipolar;
  logic       cfg_wr_p, cfg_single, conv_done_p, conv_start_p, conv_diff;
  logic       conv_ref_gnd, analog_pwr_on, int_ref_on, ref_settled;
  logic       ref_pin_oe_n, pin_is_ref, scl_hold, res_vld_p, mem_ready;
  logic       last_gnd, hit11;
  logic [2:0] setup_sel;
  logic [1:0] cfg_scan;
  logic [3:0] cfg_chan, conv_chan;
  logic [9:0] conv_raw, res_data;
  logic [9:0] exp_q[$], mem_q[$];
  int         err_count, checked, cyc, n_res;

  asr_power_ctrl #(.NUM_CH(12), .REF_WAKE_CYC(WAKE)) i_asr_power_ctrl (
    .sys_clk(sys_clk), .nrst(nrst), .bus_start_p(bus_start_p),
    .bus_stop_p(bus_stop_p), .bus_nack_p(bus_nack_p), .addr_rd_p(addr_rd_p),
    .res_rd_p(res_rd_p), .setup_wr_p(setup_wr_p), .setup_sel(setup_sel),
    .setup_clk_ext(setup_clk_ext), .setup_bipolar(setup_bipolar),
    .cfg_wr_p(cfg_wr_p), .cfg_scan(cfg_scan), .cfg_chan(cfg_chan),
    .cfg_single(cfg_single), .conv_done_p(conv_done_p), .conv_raw(conv_raw),
    .conv_start_p(conv_start_p), .conv_chan(conv_chan), .conv_diff(conv_diff),
    .conv_ref_gnd(conv_ref_gnd), .analog_pwr_on(analog_pwr_on),
    .int_ref_on(int_ref_on), .ref_settled(ref_settled),
    .ref_pin_oe_n(ref_pin_oe_n), .pin_is_ref(pin_is_ref), .scl_hold(scl_hold),
    .res_vld_p(res_vld_p), .res_data(res_data), .mem_ready(mem_ready));

  asr_conv_model i_asr_conv_model (.sys_clk(sys_clk), .nrst(nrst),
    .conv_start_p(conv_start_p), .conv_done_p(conv_done_p), .conv_raw(conv_raw));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic tick(input int n = 1);
    repeat (n) @(posedge sys_clk);
  endtask

  function automatic logic [9:0] code(input logic [9:0] r);
    return setup_bipolar ? {~r[9], r[8:0]} : r;
  endfunction

  task automatic setup(input logic [2:0] sel, input logic ext, bip);
    tick();
    setup_wr_p    <= 1'b1;
    setup_sel     <= sel;
    setup_clk_ext <= ext;
    setup_bipolar <= bip;
    tick();
    setup_wr_p    <= 1'b0;
  endtask

  task automatic cfg(input logic [1:0] scan, input logic [3:0] ch, input logic sgl);
    tick();
    cfg_wr_p   <= 1'b1;
    cfg_scan   <= scan;
    cfg_chan   <= ch;
    cfg_single <= sgl;
    tick();
    cfg_wr_p   <= 1'b0;
  endtask

  // Unarmed request sends the address with no start in front
  task automatic request(input logic armed);
    mem_q.delete();
    tick();
    bus_start_p <= armed;
    tick();
    bus_start_p <= 1'b0;
    addr_rd_p   <= 1'b1;
    tick();
    addr_rd_p   <= 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic wait_off(input int lim);
    for (int i = 0; i < lim; i++) begin
      @(negedge sys_clk);
      if (analog_pwr_on === 1'b0)
        break;
    end
    chk("pwr_down", analog_pwr_on, 0);
  endtask

  task automatic drain(input int nconv, input int nrd);
    wait_off(400);
    chk("mem_ready", mem_ready, 1);
    chk("scl_release", scl_hold, 0);
    chk("stored", mem_q.size(), nconv);
    for (int i = 0; i < nrd && mem_q.size() > 0; i++) begin
      exp_q.push_back(mem_q[i % mem_q.size()]);
      tick();
      res_rd_p <= 1'b1;
      tick();
      res_rd_p <= 1'b0;
    end
    tick(3);
    chk("res_missing", exp_q.size(), 0);
    bus_stop_p <= 1'b1;
    tick();
    bus_stop_p <= 1'b0;
    @(negedge sys_clk);
    chk("mem_clear", mem_ready, 0);
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (conv_start_p === 1'b1) begin
      last_gnd = conv_ref_gnd;
      if (pin_is_ref === 1'b1 && conv_chan === 4'hb)
        hit11 = 1'b1;
    end
    if (conv_done_p === 1'b1 && setup_clk_ext)
      exp_q.push_back(code(conv_raw));
    else if (conv_done_p === 1'b1)
      mem_q.push_back(code(conv_raw));
    if (res_vld_p === 1'b1) begin
      n_res++;
      if (exp_q.size() == 0)
        chk("res_extra", 1, 0);
      else
        chk("res_data", res_data, exp_q.pop_front());
    end
    if (cyc == 20000) begin
      err_count++;
      close_out();
    end
  end

  initial begin
    {nrst, bus_start_p, bus_stop_p, bus_nack_p, addr_rd_p, res_rd_p} = '0;
    {setup_wr_p, setup_sel, setup_clk_ext, setup_bipolar, cfg_wr_p} = '0;
    {cfg_scan, cfg_chan, hit11, last_gnd} = '0;
    cfg_single = 1'b1;
    tick(10);
    nrst <= 1'b1;
    tick(5);
    request(1'b0);
    chk("pwr_unarmed", analog_pwr_on, 0);
    chk("pin_default", pin_is_ref, 0);
    request(1'b1);
    chk("scl_hold", scl_hold, 1);
    drain(1, 2);
    $display("test defaults done");
    for (int s = 0; s < 8; s++) begin
      setup(s[2:0], 1'b0, 1'b0);
      tick();
      @(negedge sys_clk);
      chk("int_ref", int_ref_on, s[2] & s[0]);
      chk("pin_role", pin_is_ref, s[1]);
    end
    $display("test select done");
    setup(3'h5, 1'b0, 1'b1);
    tick(WAKE + 4);
    chk("settled", ref_settled, 1);
    setup(3'h5, 1'b0, 1'b1);
    request(1'b1);
    chk("pwr_up", analog_pwr_on, 1);
    drain(1, 3);
    chk("ref_kept", int_ref_on, 1);
    setup(3'h7, 1'b0, 1'b0);
    tick(WAKE + 4);
    request(1'b1);
    chk("pin_driven", ref_pin_oe_n, 0);
    drain(1, 1);
    chk("pin_hiz", ref_pin_oe_n, 1);
    $display("test internal done");
    setup(3'h2, 1'b0, 1'b0);
    cfg(asr_pkg::SCAN_UP, 4'hb, 1'b1);
    request(1'b1);
    tick();
    @(negedge sys_clk);
    chk("no_wake_wait", conv_start_p, 1);
    drain(11, 12);
    chk("ref_pin_skipped", hit11, 0);
    cfg(asr_pkg::SCAN_ONE, 4'ha, 1'b0);
    request(1'b1);
    chk("diff_flag", conv_diff, 1);
    drain(1, 1);
    chk("ref_as_ground", last_gnd, 1);
    // Repeat mode stores eight results of one channel
    cfg(asr_pkg::SCAN_REP, 4'h4, 1'b1);
    request(1'b1);
    drain(asr_pkg::REPEAT_N, 9);
    // Middle scan runs six to ten with the shared pin as reference
    cfg(asr_pkg::SCAN_MID, 4'hb, 1'b1);
    request(1'b1);
    drain(5, 5);
    chk("ref_pin_skipped", hit11, 0);
    $display("test scan done");
    setup(3'h0, 1'b1, 1'b1);
    cfg(asr_pkg::SCAN_ONE, 4'h3, 1'b1);
    for (int k = 0; k < 3; k++) begin
      n_res = 0;
      request(1'b1);
      for (int i = 0; i < 300 && n_res < 3; i++)
        tick();
      chk("still_conv", analog_pwr_on, 1);
      {bus_stop_p, bus_nack_p, bus_start_p} <= 3'b100 >> k;
      tick();
      {bus_stop_p, bus_nack_p, bus_start_p} <= 3'b000;
      wait_off(2);
      tick(12);
      exp_q.delete();
    end
    $display("test external done");
    close_out();
  end
endmodule // tb_top
`default_nettype wire
